// >>> logic/cob_params.svh
// Offsets, field positions and counts of the option bank
// Assumes byte addresses on a 32-bit APB, one word per register
`ifndef COB_PARAMS_SVH
`define COB_PARAMS_SVH
`define COB_OFF_CLK2     8'h00
`define COB_OFF_PIN3     8'h04
`define COB_OFF_CORE     8'h08
`define COB_OFF_STAT     8'h0c
`define COB_MASK_CLK2    8'h7f
`define COB_MASK_PIN3    8'h7f
`define COB_MASK_CORE    8'h03
`define COB_RST_VAL      8'h00
`define COB_B2_GENSTOP   0
`define COB_B2_SSPUOFF   1
`define COB_B2_TBPRE     2
`define COB_B2_EXTCLK    3
`define COB_B2_XTAL      4
`define COB_B2_SLOW      5
`define COB_B2_BAUDSRC   6
`define COB_B3_SPI_PIN_SELECT    0
`define COB_B3_UARTSEL   1
`define COB_B3_PORTSLW   2
`define COB_B3_MCLKSLW   3
`define COB_B3_SPISLW    4
`define COB_B3_UARTSLW   5
`define COB_B3_RNG       6
`define COB_BC_STOPEN    0
`define COB_BC_WDOFF     1
`define COB_STAB_LONG    13'h1000
`define COB_STAB_SHORT   13'h0010
`endif

// >>> logic/cob_pkg.sv
// Types of the chip option bank
// Assumes nothing beyond the params header
package cob_pkg;
    typedef enum logic [1:0] {
        COB_AMP_HIGH,
        COB_AMP_MID,
        COB_AMP_LOW,
        COB_AMP_RSVD
    } cob_amp_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } cob_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } cob_apb_rsp_t;

    typedef struct packed {
        logic        stop_enable;
        logic        watchdog_enable;
        logic        uart_clk_is_bus;
        logic        ext_osc_enable;
        logic        crystal_mode;
        logic        clock_in_pin_osc;
        logic        crystal_out_pin_osc;
        logic        mon_expect_crystal;
        logic        mon_expect_slow;
        logic [12:0] stab_count;
        cob_amp_t    amp_range;
        logic        slow_crystal;
        logic        timebase_extra_prescale;
        logic        gen_in_stop;
        logic        ss_pullup_en;
        logic        uart_tx_slew;
        logic        spi_out_slew;
        logic        master_clock_slew;
        logic        port_slew;
        logic [7:0]  porta_alt;
        logic [7:0]  portb_alt;
        logic [7:0]  portc_alt;
        logic [7:0]  porte_alt;
    } cob_opt_t;

    typedef struct packed {
        logic [7:0]  clk2;
        logic [7:0]  pin3;
        logic [7:0]  core;
        logic [2:0]  lock;
        logic [31:0] rdata;
        logic        err;
        cob_opt_t    opt;
    } cob_state_t;
endpackage

// >>> logic/cob_config_bank.sv
// Write-once chip option bank on APB with decoded option outputs
// Assumes a synchronous high reset and a zero-wait APB master
`timescale 1ns/100ps
`include "cob_params.svh"

module cob_config_bank (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire cob_pkg::cob_apb_req_t apb_req,
    output cob_pkg::cob_apb_rsp_t  apb_rsp,
    input  wire logic              stop_opcode_seen,
    input  wire logic              stop_mode,
    output cob_pkg::cob_opt_t      opt,
    output logic                   stop_illegal,
    output logic                   clocks_held_low
);
    import cob_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Option decode

    function automatic cob_opt_t decode_opts(
        input logic [7:0] clk2,
        input logic [7:0] pin3,
        input logic [7:0] core
    );
        cob_opt_t    o;
        logic        ext;
        logic        xtal;
        logic        slow;
        logic        rng;
        logic        usel;
        logic        ssel;
        o    = '0;
        ext  = clk2[`COB_B2_EXTCLK];
        xtal = clk2[`COB_B2_XTAL];
        slow = clk2[`COB_B2_SLOW];
        rng  = pin3[`COB_B3_RNG];
        usel = pin3[`COB_B3_UARTSEL];
        ssel = pin3[`COB_B3_SPI_PIN_SELECT];

        o.stop_enable     = core[`COB_BC_STOPEN];
        o.watchdog_enable = ~core[`COB_BC_WDOFF];
        o.uart_clk_is_bus = clk2[`COB_B2_BAUDSRC];

        o.ext_osc_enable      = ext;
        o.crystal_mode        = ext & xtal;
        o.clock_in_pin_osc    = ext;
        o.crystal_out_pin_osc = ext & xtal;

        o.mon_expect_crystal = xtal;
        if (xtal) begin
            o.stab_count = `COB_STAB_LONG;
        end else begin
            o.stab_count = `COB_STAB_SHORT;
        end

        o.slow_crystal    = slow;
        o.mon_expect_slow = slow;
        case ({slow, rng})
            2'b00: begin
                o.amp_range = COB_AMP_HIGH;
            end
            2'b01: begin
                o.amp_range = COB_AMP_MID;
            end
            2'b10: begin
                o.amp_range = COB_AMP_LOW;
            end
            default: begin
                o.amp_range = COB_AMP_RSVD;
            end
        endcase

        o.timebase_extra_prescale = clk2[`COB_B2_TBPRE];
        o.gen_in_stop             = clk2[`COB_B2_GENSTOP];
        o.ss_pullup_en            = ~clk2[`COB_B2_SSPUOFF];

        o.uart_tx_slew      = pin3[`COB_B3_UARTSLW];
        o.spi_out_slew      = pin3[`COB_B3_SPISLW];
        o.master_clock_slew = pin3[`COB_B3_MCLKSLW];
        o.port_slew         = pin3[`COB_B3_PORTSLW];

        // Oscillator pins on port C
        o.portc_alt[4] = ext;
        o.portc_alt[3] = ext & xtal;

        // Serial port transmit and receive
        if (usel) begin
            o.porta_alt[2] = 1'b1;
            o.porta_alt[3] = 1'b1;
        end else begin
            o.porte_alt[0] = 1'b1;
            o.porte_alt[1] = 1'b1;
        end

        // SPI data, clock and slave select
        if (ssel) begin
            o.portb_alt[3] = 1'b1;
            o.portb_alt[4] = 1'b1;
            o.portb_alt[5] = 1'b1;
            o.portc_alt[2] = 1'b1;
        end else begin
            o.portc_alt[0] = 1'b1;
            o.portc_alt[1] = 1'b1;
            o.porta_alt[5] = 1'b1;
            o.porta_alt[6] = 1'b1;
        end
        return o;
    endfunction

    localparam cob_opt_t OPT_RST = decode_opts(
        `COB_RST_VAL,
        `COB_RST_VAL,
        `COB_RST_VAL
    );

    ////////////////////////////////////////////////////////////////////
    // State

    cob_state_t s_r;
    cob_state_t s_nxt;

    logic       setup_ph;
    logic       wr_acc;
    logic       wr_lane;
    logic       hit_clk2;
    logic       hit_pin3;
    logic       hit_core;
    logic       hit_stat;
    logic       mapped;

    assign setup_ph = apb_req.psel & ~apb_req.penable;
    assign wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign wr_lane  = apb_req.pstrb[0];
    assign hit_clk2 = apb_req.paddr == `COB_OFF_CLK2;
    assign hit_pin3 = apb_req.paddr == `COB_OFF_PIN3;
    assign hit_core = apb_req.paddr == `COB_OFF_CORE;
    assign hit_stat = apb_req.paddr == `COB_OFF_STAT;
    assign mapped   = hit_clk2 | hit_pin3 | hit_core | hit_stat;

    ////////////////////////////////////////////////////////////////////
    // Per-register write decode

    logic [2:0] reg_hit;
    logic [2:0] reg_take;
    logic [7:0] reg_mask [3];
    logic [7:0] wr_byte;

    assign wr_byte     = apb_req.pwdata[7:0];
    assign reg_hit[0]  = hit_clk2;
    assign reg_hit[1]  = hit_pin3;
    assign reg_hit[2]  = hit_core;
    assign reg_mask[0] = `COB_MASK_CLK2;
    assign reg_mask[1] = `COB_MASK_PIN3;
    assign reg_mask[2] = `COB_MASK_CORE;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_take
            // First write after reset only
            assign reg_take[g] = wr_acc & wr_lane & reg_hit[g] & ~s_r.lock[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt = s_r;

        // Read data and error captured in the setup cycle
        if (setup_ph) begin
            s_nxt.rdata = '0;
            s_nxt.err   = ~mapped;
            if (hit_clk2) begin
                s_nxt.rdata[7:0] = s_r.clk2;
            end
            if (hit_pin3) begin
                s_nxt.rdata[7:0] = s_r.pin3;
            end
            if (hit_core) begin
                s_nxt.rdata[7:0] = s_r.core;
            end
            if (hit_stat) begin
                s_nxt.rdata[2:0] = s_r.lock;
                s_nxt.rdata[5:4] = s_r.opt.amp_range;
            end
        end

        // First write to each register latches it, later ones are dropped
        if (reg_take[0]) begin
            s_nxt.clk2    = wr_byte & reg_mask[0];
            s_nxt.lock[0] = 1'b1;
        end
        if (reg_take[1]) begin
            s_nxt.pin3    = wr_byte & reg_mask[1];
            s_nxt.lock[1] = 1'b1;
        end
        if (reg_take[2]) begin
            s_nxt.core    = wr_byte & reg_mask[2];
            s_nxt.lock[2] = 1'b1;
        end

        // Slow crystal pins the range bit low
        if (s_nxt.clk2[`COB_B2_SLOW]) begin
            s_nxt.pin3[`COB_B3_RNG] = 1'b0;
        end

        s_nxt.opt = decode_opts(s_nxt.clk2, s_nxt.pin3, s_nxt.core);
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r.clk2  <= `COB_RST_VAL;
            s_r.pin3  <= `COB_RST_VAL;
            s_r.core  <= `COB_RST_VAL;
            s_r.lock  <= '0;
            s_r.rdata <= '0;
            s_r.err   <= 1'b0;
            s_r.opt   <= OPT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign apb_rsp.prdata  = s_r.rdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = s_r.err & apb_req.psel & apb_req.penable;

    assign opt             = s_r.opt;
    assign stop_illegal    = stop_opcode_seen & ~s_r.opt.stop_enable;
    assign clocks_held_low = stop_mode & ~s_r.opt.gen_in_stop;

endmodule

// >>> verif/cob_chk.sv
// Concurrent checks on the option bank ports
// Assumes the bank top and its package are compiled first
`timescale 1ns/100ps
`include "cob_params.svh"
module cob_chk (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire cob_pkg::cob_apb_req_t apb_req,
    input wire cob_pkg::cob_apb_rsp_t apb_rsp,
    input wire logic                  stop_opcode_seen,
    input wire logic                  stop_mode,
    input wire cob_pkg::cob_opt_t     opt,
    input wire logic                  stop_illegal,
    input wire logic                  clocks_held_low
);
    import cob_pkg::*;
    wire acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    AST_STOP_ILLEGAL: assert property (
        stop_illegal == (stop_opcode_seen & ~opt.stop_enable))
        else $error("stop opcode flag wrong");
    AST_HELD_LOW: assert property (clocks_held_low == (stop_mode & ~opt.gen_in_stop))
        else $error("clock hold flag wrong");
    AST_XTAL_NEEDS_EXT: assert property (opt.crystal_mode |-> opt.ext_osc_enable)
        else $error("crystal mode without external clock");
    AST_STAB: assert property (opt.stab_count == (opt.mon_expect_crystal ?
                                                  `COB_STAB_LONG : `COB_STAB_SHORT))
        else $error("stabilization count wrong");
    AST_SLOW_RANGE: assert property (opt.slow_crystal |-> opt.amp_range == COB_AMP_LOW)
        else $error("range bit not forced low");
    AST_RESET_CLEAR: assert property ($past(rst) |-> opt.watchdog_enable &&
                                      !opt.stop_enable && opt.stab_count == 13'h0010
                                      && opt.ss_pullup_en)
        else $error("options not cleared by reset");
    AST_ONLY_BY_WRITE: assert property (!$stable(opt) |-> $past(rst) || $past(acc))
        else $error("options changed without a write");
    AST_OSC_PINS: assert property (opt.portc_alt[4] == opt.clock_in_pin_osc
                                   && opt.portc_alt[3] == opt.crystal_out_pin_osc)
        else $error("oscillator pin placement wrong");
    AST_UART_PINS: assert property (
        (opt.porta_alt[3:2] == 2'h3) != (opt.porte_alt[1:0] == 2'h3))
        else $error("serial pins placed twice or not at all");
    AST_SPI_PINS: assert property (
        (opt.portb_alt[5:3] == 3'h7) != (opt.porta_alt[6:5] == 2'h3))
        else $error("spi pins placed twice or not at all");
endmodule
bind cob_config_bank cob_chk i_cob_chk (.clk(clk), .rst(rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .stop_opcode_seen(stop_opcode_seen), .stop_mode(stop_mode), .opt(opt),
    .stop_illegal(stop_illegal), .clocks_held_low(clocks_held_low));

// >>> verif/cob_config_bank_tb.sv
// Self-checking bench for the option bank
// Assumes the bank top, its package and the bound checker
`timescale 1ns/100ps
module cob_config_bank_tb;
    import cob_pkg::*;
    logic         clk, rst, stop_opcode_seen, stop_mode, stop_illegal, clocks_held_low;
    cob_apb_req_t apb_req;
    cob_apb_rsp_t apb_rsp;
    cob_opt_t     opt;
    int           errors, checked, seed, it;
    logic [32:0]  exp_q[$];
    logic [7:0]   c2, c3, cc;
    cob_config_bank i_cob_config_bank (.clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .stop_opcode_seen(stop_opcode_seen), .stop_mode(stop_mode), .opt(opt),
        .stop_illegal(stop_illegal), .clocks_held_low(clocks_held_low));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, wr, a, {24'h0, d}, 4'hf};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge clk);
            if (apb_rsp.pready === 1'b1) break;
        end
        if (k == 16) begin
            errors++;
            summarize();
        end
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        exp_q.push_back(exp);
        apb(1'b0, a, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk)
        if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready === 1'b1
            && exp_q.size() > 0)
            check({apb_rsp.pslverr, apb_rsp.prdata}, exp_q.pop_front());
    always @(posedge clk) begin
        stop_opcode_seen <= $random(seed);
        stop_mode <= $random(seed);
    end
    initial begin
        seed = 34763;
        errors = 0;
        checked = 0;
        apb_req = '0;
        stop_opcode_seen = 1'b0;
        stop_mode = 1'b0;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (it = 0; it < 10; it++) begin
            if (it > 0) begin
                @(posedge clk);
                rst <= 1'b1;
                repeat (2) @(posedge clk);
                rst <= 1'b0;
            end
            rd(8'h00, 33'h0);
            rd(8'h04, 33'h0);
            rd(8'h08, 33'h0);
            c2 = (it == 0) ? 8'h20 : (it == 1) ? 8'h18 : 8'($random(seed));
            c3 = (it < 2) ? 8'h40 : 8'($random(seed));
            cc = 8'($random(seed));
            apb(1'b1, 8'h00, c2);
            apb(1'b1, 8'h04, c3);
            apb(1'b1, 8'h08, cc);
            apb(1'b1, 8'h00, ~c2);
            apb(1'b1, 8'h04, ~c3);
            apb(1'b1, 8'h08, ~cc);
            apb(1'b1, 8'h10, 8'hff);
            c2 &= 8'h7f;
            c3 &= c2[5] ? 8'h3f : 8'h7f;
            cc &= 8'h03;
            rd(8'h00, {25'h0, c2});
            rd(8'h04, {25'h0, c3});
            rd(8'h08, {25'h0, cc});
            rd(8'h10, 33'h1_0000_0000);
            @(posedge clk);
            #1;
            check(
                  {opt.stop_enable, opt.watchdog_enable, opt.uart_clk_is_bus, opt.crystal_mode,
                   opt.clock_in_pin_osc, opt.mon_expect_slow, opt.amp_range,
                   opt.timebase_extra_prescale, opt.gen_in_stop, opt.ss_pullup_en, opt.uart_tx_slew,
                   opt.spi_out_slew, opt.master_clock_slew, opt.port_slew, opt.stab_count},
                  {cc[0], !cc[1], c2[6], c2[3] & c2[4], c2[3], c2[5], c2[5], c3[6], c2[2], c2[0],
                   !c2[1], c3[5], c3[4], c3[3], c3[2], c2[4] ? 13'h1000 : 13'h0010});
            check(
                  {opt.porta_alt, opt.portb_alt, opt.portc_alt, opt.porte_alt},
                  {1'b0, {2{~c3[0]}}, 1'b0, {2{c3[1]}}, 2'b00, 2'b00, {3{c3[0]}}, 3'b000, 3'b000,
                   c2[3], c2[3] & c2[4], c3[0], {2{~c3[0]}}, 6'h00, {2{~c3[1]}}});
            check(
                  {opt.mon_expect_crystal, opt.ext_osc_enable, opt.crystal_out_pin_osc,
                   opt.slow_crystal},
                  {c2[4], c2[3], c2[3] & c2[4], c2[5]});
            check({stop_illegal, clocks_held_low},
                  {stop_opcode_seen & ~cc[0], stop_mode & ~c2[0]});
        end
        summarize();
    end
endmodule
